// File: mbv_regs.vh
`ifndef MBV_REGS_VH
`define MBV_REGS_VH
// register offsets
`define MBV_PIN_FUNC_ADDR 8'h3E
`define MBV_SETTINGS_ADDR 8'h3F
`define MBV_ASSIGN_ADDR 8'h40
`define MBV_DEBOUNCE_ADDR 8'h41
// reset values
`define MBV_PIN_FUNC_RST 8'h11
`define MBV_SETTINGS_RST 8'h00
`define MBV_ASSIGN_RST 8'h87
`define MBV_DEBOUNCE_RST 8'h05
// field positions
`define MBV_FUNC_MSB 4
`define MBV_INIT_MSB 7
`define MBV_INIT_LSB 3
`define MBV_HOLD_MSB 2
`define MBV_STEP_MSB 7
`define MBV_STEP_LSB 6
`define MBV_RATE_MSB 5
`define MBV_RATE_LSB 3
`define MBV_CONV_MSB 2
`define MBV_DEB_MSB 2
// pin function codes
`define MBV_FN_SERIAL 5'h00
`define MBV_FN_BYPASS 5'h0F
`define MBV_FN_VOL_UP 5'h10
`define MBV_FN_VOL_DOWN 5'h11
`define MBV_FN_CLOCK_OUTPUT_FUNCTION 5'h12
// converter assignment codes
`define MBV_CONV_RESERVED 3'h6
`define MBV_CONV_NONE 3'h7
// attenuation in 0.375 dB units
`define MBV_STEP_MDB 375
`define MBV_ATT_MAX 9'h100
// timing
`define MBV_CYC_PER_US 125
`define MBV_DEB0_US 300
`define MBV_DEB1_US 600
`define MBV_DEB2_US 900
`define MBV_DEB3_US 5000
`define MBV_DEB4_US 10000
`define MBV_DEB5_US 20000
`define MBV_DEB6_US 40000
`define MBV_HOLD0_MS 150
`define MBV_HOLD1_MS 300
`define MBV_HOLD2_MS 450
`define MBV_HOLD3_MS 600
`define MBV_HOLD4_MS 900
`define MBV_HOLD5_MS 1200
`define MBV_RATE0_DBPS 60
`define MBV_RATE1_DBPS 48
`define MBV_RATE2_DBPS 36
`define MBV_RATE3_DBPS 30
`define MBV_RATE4_DBPS 24
`define MBV_RATE5_DBPS 18
`define MBV_RATE6_DBPS 12
`define MBV_RATE7_DBPS 6
`define MBV_US_CYC(t) ((t) * `MBV_CYC_PER_US)
`define MBV_MS_CYC(t) ((t) * `MBV_CYC_PER_US * 1000)
`define MBV_RATE_CYC(r) ((`MBV_STEP_MDB * `MBV_CYC_PER_US * 1000) / (r))
`endif

// File: mbv_pin_volume.v
// Contract
// - bits [4:0] of the pin function register pick the pin role, 00000 drives the second serial output.
// - codes 00001 to 01010 make the pin a mute request for the listed converters, 01011-01110 are reserved.
// - code 01111 makes the pin an input that requests the ADC to DAC bypass while asserted.
// - code 10000 makes the pin the volume-up button and 10001 the volume-down button.
// - code 10010 drives the clock output onto the pin.
// - the pin function register resets to 0x11 and its bits [7:5] read as zero.
// - bits [7:3] of the settings register give the start attenuation in 1.5 dB counts.
// - bits [2:0] of the settings register pick a hold time of 150 to 1200 ms before ramping.
// - bits [7:6] of the assignment register pick a press step of 0.375, 1.5, 3.0 or 4.5 dB.
// - bits [5:3] of the assignment register pick the held ramp rate, 000 being 60 dB/s.
// - the assignment register resets to 0x87, leaving push-button volume disabled.
// - bits [2:0] of the assignment register choose the converters, 111 disables the controller.
// - pin inputs are debounced for 300 us to 40 ms or not at all, 20 ms after reset.
`timescale 1ns/1ps
`include "mbv_regs.vh"

module mbv_pin_volume #(
    parameter DEB0_CYC = `MBV_US_CYC(`MBV_DEB0_US),
    parameter DEB1_CYC = `MBV_US_CYC(`MBV_DEB1_US),
    parameter DEB2_CYC = `MBV_US_CYC(`MBV_DEB2_US),
    parameter DEB3_CYC = `MBV_US_CYC(`MBV_DEB3_US),
    parameter DEB4_CYC = `MBV_US_CYC(`MBV_DEB4_US),
    parameter DEB5_CYC = `MBV_US_CYC(`MBV_DEB5_US),
    parameter DEB6_CYC = `MBV_US_CYC(`MBV_DEB6_US),
    parameter HOLD0_CYC = `MBV_MS_CYC(`MBV_HOLD0_MS),
    parameter HOLD1_CYC = `MBV_MS_CYC(`MBV_HOLD1_MS),
    parameter HOLD2_CYC = `MBV_MS_CYC(`MBV_HOLD2_MS),
    parameter HOLD3_CYC = `MBV_MS_CYC(`MBV_HOLD3_MS),
    parameter HOLD4_CYC = `MBV_MS_CYC(`MBV_HOLD4_MS),
    parameter HOLD5_CYC = `MBV_MS_CYC(`MBV_HOLD5_MS),
    parameter RATE0_CYC = `MBV_RATE_CYC(`MBV_RATE0_DBPS),
    parameter RATE1_CYC = `MBV_RATE_CYC(`MBV_RATE1_DBPS),
    parameter RATE2_CYC = `MBV_RATE_CYC(`MBV_RATE2_DBPS),
    parameter RATE3_CYC = `MBV_RATE_CYC(`MBV_RATE3_DBPS),
    parameter RATE4_CYC = `MBV_RATE_CYC(`MBV_RATE4_DBPS),
    parameter RATE5_CYC = `MBV_RATE_CYC(`MBV_RATE5_DBPS),
    parameter RATE6_CYC = `MBV_RATE_CYC(`MBV_RATE6_DBPS),
    parameter RATE7_CYC = `MBV_RATE_CYC(`MBV_RATE7_DBPS)
)(
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [7:0] reg_rdata,
    input wire pin_in,
    output reg pin_out,
    output reg pin_oe_n,
    input wire second_serial_output,
    input wire clock_output_function,
    output reg [3:0] adc_mute_req,
    output reg [1:0] dac_mute_req,
    output reg bypass_req,
    output reg pb_active,
    output reg [3:0] adc_pb_sel,
    output reg [1:0] dac_pb_sel,
    output reg [8:0] pb_attenuation
);

    localparam ST_IDLE = 2'd0;
    localparam ST_HOLD = 2'd1;
    localparam ST_RAMP = 2'd2;

    reg [7:0] pin_function_code;
    reg [7:0] vol_settings;
    reg [7:0] vol_assign;
    reg [7:0] deb_mode;
    reg settings_written;
    reg sync1, sync2, sync3;
    reg stable_in;
    reg deb_level;
    reg deb_prev;
    reg [27:0] deb_cnt;
    reg [27:0] time_cnt;
    reg [1:0] state;
    reg was_enabled;
    reg [7:0] next_rdata;

    wire [4:0] func = pin_function_code[`MBV_FUNC_MSB:0];
    wire [2:0] conv = vol_assign[`MBV_CONV_MSB:0];
    wire enabled = (conv != `MBV_CONV_NONE) && (conv != `MBV_CONV_RESERVED);
    wire is_up = (func == `MBV_FN_VOL_UP);
    wire is_down = (func == `MBV_FN_VOL_DOWN);
    wire btn_role = enabled && (is_up || is_down);
    wire press = btn_role && deb_level && !deb_prev;
    wire held = btn_role && deb_level;

    // debounce length per mode code
    function [27:0] deb_len;
        input [2:0] code;
        begin
            case (code)
                3'd0: deb_len = DEB0_CYC[27:0];
                3'd1: deb_len = DEB1_CYC[27:0];
                3'd2: deb_len = DEB2_CYC[27:0];
                3'd3: deb_len = DEB3_CYC[27:0];
                3'd4: deb_len = DEB4_CYC[27:0];
                3'd5: deb_len = DEB5_CYC[27:0];
                default: deb_len = DEB6_CYC[27:0];
            endcase
        end
    endfunction

    // hold time per code, unlisted codes take the longest
    function [27:0] hold_len;
        input [2:0] code;
        begin
            case (code)
                3'd0: hold_len = HOLD0_CYC[27:0];
                3'd1: hold_len = HOLD1_CYC[27:0];
                3'd2: hold_len = HOLD2_CYC[27:0];
                3'd3: hold_len = HOLD3_CYC[27:0];
                3'd4: hold_len = HOLD4_CYC[27:0];
                default: hold_len = HOLD5_CYC[27:0];
            endcase
        end
    endfunction

    // cycles per 0.375 dB ramp step
    function [27:0] rate_len;
        input [2:0] code;
        begin
            case (code)
                3'd0: rate_len = RATE0_CYC[27:0];
                3'd1: rate_len = RATE1_CYC[27:0];
                3'd2: rate_len = RATE2_CYC[27:0];
                3'd3: rate_len = RATE3_CYC[27:0];
                3'd4: rate_len = RATE4_CYC[27:0];
                3'd5: rate_len = RATE5_CYC[27:0];
                3'd6: rate_len = RATE6_CYC[27:0];
                default: rate_len = RATE7_CYC[27:0];
            endcase
        end
    endfunction

    // saturating move by a number of 0.375 dB units
    function [8:0] move_att;
        input [8:0] att;
        input [3:0] units;
        input up;
        reg [9:0] sum;
        begin
            sum = {1'b0, att} + {6'h00, units};
            if (up)
                move_att = (att > {5'h00, units}) ? att - {5'h00, units} : 9'h000;
            else
                move_att = (sum > {1'b0, `MBV_ATT_MAX}) ? `MBV_ATT_MAX : sum[8:0];
        end
    endfunction

    // press step in 0.375 dB units
    function [3:0] step_units;
        input [1:0] code;
        begin
            case (code)
                2'd0: step_units = 4'h1;
                2'd1: step_units = 4'h4;
                2'd2: step_units = 4'h8;
                default: step_units = 4'hC;
            endcase
        end
    endfunction

    // register writes, reserved bits kept at zero
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_function_code <= `MBV_PIN_FUNC_RST;
            vol_settings <= `MBV_SETTINGS_RST;
            vol_assign <= `MBV_ASSIGN_RST;
            deb_mode <= `MBV_DEBOUNCE_RST;
            settings_written <= 1'b0;
        end
        else if (ce && reg_we)
        begin
            case (reg_addr)
                `MBV_PIN_FUNC_ADDR: pin_function_code <= {3'h0, reg_wdata[4:0]};
                `MBV_SETTINGS_ADDR:
                begin
                    vol_settings <= reg_wdata;
                    settings_written <= 1'b1;
                end
                `MBV_ASSIGN_ADDR: vol_assign <= reg_wdata;
                `MBV_DEBOUNCE_ADDR: deb_mode <= {5'h00, reg_wdata[2:0]};
                default: ;
            endcase
        end
    end

    // read mux, unmapped offsets read zero
    always @*
    begin
        case (reg_addr)
            `MBV_PIN_FUNC_ADDR: next_rdata = pin_function_code;
            `MBV_SETTINGS_ADDR: next_rdata = vol_settings;
            `MBV_ASSIGN_ADDR: next_rdata = vol_assign;
            `MBV_DEBOUNCE_ADDR: next_rdata = deb_mode;
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (ce && reg_re)
            reg_rdata <= next_rdata;
    end

    // three-stage pin sync, a change only counts once stages two and three agree
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            stable_in <= 1'b0;
        end
        else if (ce)
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3)
                stable_in <= sync3;
        end
    end

    // debounce: the new level must persist for the whole window
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            deb_level <= 1'b0;
            deb_prev <= 1'b0;
            deb_cnt <= 28'h0000000;
        end
        else if (ce)
        begin
            deb_prev <= deb_level;
            if (deb_mode[`MBV_DEB_MSB:0] == 3'h7)
            begin
                deb_level <= stable_in;
                deb_cnt <= 28'h0000000;
            end
            else if (stable_in == deb_level)
                deb_cnt <= 28'h0000000;
            else if (deb_cnt >= deb_len(deb_mode[`MBV_DEB_MSB:0]) - 28'h0000001)
            begin
                deb_level <= stable_in;
                deb_cnt <= 28'h0000000;
            end
            else
                deb_cnt <= deb_cnt + 28'h0000001;
        end
    end

    // press, hold and ramp of the button volume
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            time_cnt <= 28'h0000000;
            was_enabled <= 1'b0;
            pb_attenuation <= `MBV_ATT_MAX;
        end
        else if (ce)
        begin
            was_enabled <= enabled;
            if (enabled && !was_enabled)
            begin
                // unset settings fall back to full attenuation
                if (settings_written)
                    pb_attenuation <= {2'h0, vol_settings[`MBV_INIT_MSB:`MBV_INIT_LSB], 2'h0};
                else
                    pb_attenuation <= `MBV_ATT_MAX;
                state <= ST_IDLE;
                time_cnt <= 28'h0000000;
            end
            else if (!held)
            begin
                state <= ST_IDLE;
                time_cnt <= 28'h0000000;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (press)
                        begin
                            pb_attenuation <= move_att(pb_attenuation,
                                step_units(vol_assign[`MBV_STEP_MSB:`MBV_STEP_LSB]),
                                is_up);
                            state <= ST_HOLD;
                            time_cnt <= 28'h0000000;
                        end
                    end
                    ST_HOLD:
                    begin
                        if (time_cnt >= hold_len(vol_settings[`MBV_HOLD_MSB:0]) - 28'h0000001)
                        begin
                            state <= ST_RAMP;
                            time_cnt <= 28'h0000000;
                        end
                        else
                            time_cnt <= time_cnt + 28'h0000001;
                    end
                    ST_RAMP:
                    begin
                        // ramp moves in the finest unit, exact except for the truncated 48, 36 and 18 dB/s intervals
                        if (time_cnt >= rate_len(vol_assign[`MBV_RATE_MSB:`MBV_RATE_LSB])
                            - 28'h0000001)
                        begin
                            pb_attenuation <= move_att(pb_attenuation, 4'h1, is_up);
                            time_cnt <= 28'h0000000;
                        end
                        else
                            time_cnt <= time_cnt + 28'h0000001;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                        time_cnt <= 28'h0000000;
                    end
                endcase
            end
        end
    end

    // pin role decode, all outputs registered
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            adc_mute_req <= 4'h0;
            dac_mute_req <= 2'h0;
            bypass_req <= 1'b0;
            pb_active <= 1'b0;
            adc_pb_sel <= 4'h0;
            dac_pb_sel <= 2'h0;
        end
        else if (ce)
        begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            if (func == `MBV_FN_SERIAL)
            begin
                pin_out <= second_serial_output;
                pin_oe_n <= 1'b0;
            end
            else if (func == `MBV_FN_CLOCK_OUTPUT_FUNCTION)
            begin
                pin_out <= clock_output_function;
                pin_oe_n <= 1'b0;
            end
            adc_mute_req <= 4'h0;
            dac_mute_req <= 2'h0;
            if (deb_level)
            begin
                case (func)
                    5'h01: adc_mute_req <= 4'h1;
                    5'h02: adc_mute_req <= 4'h2;
                    5'h03: adc_mute_req <= 4'h4;
                    5'h04: adc_mute_req <= 4'h8;
                    5'h05: adc_mute_req <= 4'h3;
                    5'h06: adc_mute_req <= 4'hC;
                    5'h07: adc_mute_req <= 4'hF;
                    5'h08: dac_mute_req <= 2'h1;
                    5'h09: dac_mute_req <= 2'h2;
                    5'h0A: dac_mute_req <= 2'h3;
                    default: ;
                endcase
            end
            bypass_req <= deb_level && (func == `MBV_FN_BYPASS);
            pb_active <= enabled;
            case (conv)
                3'd0: {adc_pb_sel, dac_pb_sel} <= 6'h0C;
                3'd1: {adc_pb_sel, dac_pb_sel} <= 6'h30;
                3'd2: {adc_pb_sel, dac_pb_sel} <= 6'h3C;
                3'd3: {adc_pb_sel, dac_pb_sel} <= 6'h03;
                3'd4: {adc_pb_sel, dac_pb_sel} <= 6'h01;
                3'd5: {adc_pb_sel, dac_pb_sel} <= 6'h02;
                default: {adc_pb_sel, dac_pb_sel} <= 6'h00;
            endcase
        end
    end

endmodule // mbv_pin_volume

// File: mbv_pin_volume_asserts.sv
`timescale 1ns/1ps
module mbv_pin_volume_chk (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    input wire [7:0] reg_rdata,
    input wire pin_out,
    input wire pin_oe_n,
    input wire second_serial_output,
    input wire clock_output_function,
    input wire [3:0] adc_mute_req,
    input wire [1:0] dac_mute_req,
    input wire bypass_req,
    input wire pb_active,
    input wire [8:0] pb_attenuation
);
    reg [4:0] func_m;
    reg [2:0] conv_m;
    wire role_in;
    wire mute_role;
    wire pb_off;
    // shadow of role and assignment fields, updated on the same edge as the device
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            func_m <= 5'h11;
            conv_m <= 3'h7;
        end
        else if (ce && reg_we && reg_addr == 8'h3E)
            func_m <= reg_wdata[4:0];
        else if (ce && reg_we && reg_addr == 8'h40)
            conv_m <= reg_wdata[2:0];
    end
    // decode helpers; outputs lag the shadow by one cycle so two samples are required
    assign role_in = (func_m != 5'h00) && (func_m != 5'h12);
    assign mute_role = (func_m >= 5'h01) && (func_m <= 5'h0A);
    assign pb_off = (conv_m >= 3'h6);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_serial_out: assert property (func_m == 5'h00 && $past(func_m) == 5'h00 |->
        !pin_oe_n && pin_out == $past(second_serial_output))
        else $error("serial role not driven onto pin");
    a_clock_out: assert property (func_m == 5'h12 && $past(func_m) == 5'h12 |->
        !pin_oe_n && pin_out == $past(clock_output_function))
        else $error("clock role not driven onto pin");
    a_input_role: assert property (role_in && $past(role_in) |-> pin_oe_n)
        else $error("pin driven in an input role");
    a_no_mute: assert property (!mute_role && $past(mute_role) == 1'b0 |->
        adc_mute_req == 4'h0 && dac_mute_req == 2'h0)
        else $error("mute raised outside a mute role");
    a_no_bypass: assert property (func_m != 5'h0F && $past(func_m) != 5'h0F |-> !bypass_req)
        else $error("bypass raised outside bypass role");
    a_reserved_bits: assert property (ce && reg_re && reg_addr == 8'h3E |=>
        reg_rdata[7:5] == 3'h0)
        else $error("reserved role bits read nonzero");
    a_pb_off: assert property (pb_off && $past(pb_off) |-> !pb_active)
        else $error("button volume active while unassigned");
    a_att_limit: assert property (pb_attenuation <= 9'h100)
        else $error("attenuation beyond full scale");
    a_step_size: assert property (pb_active && $past(pb_active) && $changed(pb_attenuation) |->
        (pb_attenuation - $past(pb_attenuation) <= 12) ||
        ($past(pb_attenuation) - pb_attenuation <= 12))
        else $error("volume moved more than the largest step");
endmodule // mbv_pin_volume_chk

bind mbv_pin_volume mbv_pin_volume_chk mbv_pin_volume_chk_i (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .second_serial_output(second_serial_output), .clock_output_function(clock_output_function),
    .adc_mute_req(adc_mute_req), .dac_mute_req(dac_mute_req), .bypass_req(bypass_req),
    .pb_active(pb_active), .pb_attenuation(pb_attenuation));

// File: mbv_button_model.sv
`timescale 1ns/1ps
module mbv_button_model (
    input wire clk,
    input wire pressed,
    input wire glitch,
    output reg pin_in
);
    reg last;
    reg [1:0] chatter;
    initial
    begin
        pin_in = 1'b0;
        last = 1'b0;
        chatter = 2'h0;
    end
    // contacts chatter after every change, shorter than any debounce window
    always @(posedge clk)
    begin
        last <= pressed;
        if (pressed != last)
            chatter <= 2'h3;
        else if (chatter != 2'h0)
            chatter <= chatter - 2'h1;
        if (chatter != 2'h0)
            pin_in <= ~pin_in;
        else
            pin_in <= pressed ^ glitch;
    end
endmodule // mbv_button_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg clk, sys_rst, ce, reg_we, reg_re, pressed, glitch, ser, clko;
    reg [7:0] reg_addr, reg_wdata;
    reg [8:0] a;
    wire [7:0] reg_rdata;
    wire pin_in, pin_out, pin_oe_n, bypass_req, pb_active;
    wire [3:0] adc_mute_req, adc_pb_sel;
    wire [1:0] dac_mute_req, dac_pb_sel;
    wire [8:0] pb_attenuation;
    integer err_total, checks_done, cyc, i, n;
    // role code, adc mutes, dac mutes, bypass
    reg [11:0] rows [0:14] = '{12'h088, 12'h110, 12'h1A0, 12'h240, 12'h298, 12'h360,
        12'h3F8, 12'h402, 12'h484, 12'h506, 12'h580, 12'h600, 12'h680, 12'h700, 12'h781};
    // adc selection, dac selection per assignment code
    reg [5:0] conv_rows [0:5] = '{6'h0C, 6'h30, 6'h3C, 6'h03, 6'h01, 6'h02};

    // short counts keep the run brief; only the reset hold and rate codes, the reset debounce code and debounce off (code 7) are used
    mbv_pin_volume #(.DEB5_CYC(4), .HOLD0_CYC(60), .RATE0_CYC(6)) mbv_pin_volume_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .second_serial_output(ser), .clock_output_function(clko),
        .adc_mute_req(adc_mute_req), .dac_mute_req(dac_mute_req), .bypass_req(bypass_req),
        .pb_active(pb_active), .adc_pb_sel(adc_pb_sel), .dac_pb_sel(dac_pb_sel),
        .pb_attenuation(pb_attenuation));

    mbv_button_model mbv_button_model_i (.clk(clk), .pressed(pressed), .glitch(glitch),
        .pin_in(pin_in));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // serial and clock sources keep moving so the pin routing is always exercised
    always @(posedge clk)
    begin
        #1;
        ser = ~ser ^ cyc[1];
        clko = ~clko;
    end

    task tick(input integer k);
    begin
        repeat (k) @(posedge clk);
        #1;
    end
    endtask

    task chk(input [8:0] got, input [8:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task wr(input [7:0] ad, input [7:0] d);
    begin
        reg_addr = ad;
        reg_wdata = d;
        reg_we = 1'b1;
        tick(1);
        reg_we = 1'b0;
        tick(4);
    end
    endtask

    task rd(input [7:0] ad, input [7:0] exp);
    begin
        reg_addr = ad;
        reg_re = 1'b1;
        tick(1);
        reg_re = 1'b0;
        tick(1);
        chk(reg_rdata, exp);
    end
    endtask

    task press(input integer k);
    begin
        pressed = 1'b1;
        tick(k);
        pressed = 1'b0;
        tick(25);
    end
    endtask

    task end_sim;
    begin
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            end_sim;
        end
    end

    initial
    begin
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        reg_we = 1'b0;
        reg_re = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pressed = 1'b0;
        glitch = 1'b0;
        ser = 1'b0;
        clko = 1'b0;
        tick(12);
        sys_rst = 1'b0;
        chk(pb_attenuation, 9'h100);
        chk(pin_oe_n, 9'h001);
        chk(pb_active, 9'h000);
        rd(8'h3E, 8'h11);
        rd(8'h3F, 8'h00);
        rd(8'h40, 8'h87);
        rd(8'h41, 8'h05);
        rd(8'h42, 8'h00);
        // frozen clock enable: a write must not land, nor count as settings written
        ce = 1'b0;
        wr(8'h3F, 8'hAA);
        ce = 1'b1;
        rd(8'h3F, 8'h00);
        wr(8'h3E, 8'hFF);
        rd(8'h3E, 8'h1F);
        // every mute, reserved and bypass role with the button held, then released
        for (i = 0; i < 15; i = i + 1)
        begin
            wr(8'h3E, {3'h0, rows[i][11:7]});
            pressed = 1'b1;
            tick(20);
            chk(adc_mute_req, rows[i][6:3]);
            chk(dac_mute_req, rows[i][2:1]);
            chk(bypass_req, rows[i][0]);
            pressed = 1'b0;
            tick(20);
            chk({adc_mute_req, dac_mute_req, bypass_req}, 9'h000);
        end
        // a short pulse is ignored, then passes once debounce is switched off
        wr(8'h3E, 8'h07);
        for (i = 0; i < 2; i = i + 1)
        begin
            glitch = 1'b1;
            tick(2);
            glitch = 1'b0;
            n = 0;
            repeat (20)
            begin
                tick(1);
                n = n | adc_mute_req;
            end
            chk(n, i ? 9'h00F : 9'h000);
            wr(8'h41, i ? 8'h05 : 8'hFF);
            rd(8'h41, i ? 8'h05 : 8'h07);
        end
        wr(8'h3E, 8'h00);
        chk(pin_oe_n, 9'h000);
        wr(8'h3E, 8'h12);
        chk(pin_oe_n, 9'h000);
        // enable without settings written: starts fully attenuated
        wr(8'h3E, 8'h11);
        wr(8'h40, 8'h80);
        chk(pb_active, 9'h001);
        chk(pb_attenuation, 9'h100);
        chk(adc_pb_sel, 9'h003);
        press(20);
        chk(pb_attenuation, 9'h100);
        wr(8'h3E, 8'h10);
        press(20);
        chk(pb_attenuation, 9'h0F8);
        // held button: one step, hold time, then one unit per rate interval
        pressed = 1'b1;
        a = pb_attenuation;
        n = 0;
        while (pb_attenuation === a && n < 40)
        begin
            tick(1);
            n = n + 1;
        end
        chk(pb_attenuation, 9'h0F0);
        a = pb_attenuation;
        n = 0;
        while (pb_attenuation === a && n < 200)
        begin
            tick(1);
            n = n + 1;
        end
        // hold of 60 cycles, then one rate interval of 6
        chk(n, 9'h042);
        chk(a - pb_attenuation, 9'h001);
        a = pb_attenuation;
        n = 0;
        while (pb_attenuation === a && n < 40)
        begin
            tick(1);
            n = n + 1;
        end
        chk(n, 9'h006);
        pressed = 1'b0;
        tick(25);
        // settings written first: start level comes from the settings register
        wr(8'h3F, 8'h28);
        wr(8'h40, 8'h87);
        chk(pb_active, 9'h000);
        wr(8'h40, 8'hC1);
        chk(pb_attenuation, 9'h014);
        press(20);
        chk(pb_attenuation, 9'h008);
        press(20);
        chk(pb_attenuation, 9'h000);
        press(20);
        chk(pb_attenuation, 9'h000);
        wr(8'h3E, 8'h11);
        wr(8'h40, 8'h01);
        press(20);
        chk(pb_attenuation, 9'h001);
        wr(8'h40, 8'h41);
        press(20);
        chk(pb_attenuation, 9'h005);
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(8'h40, {5'h10, i[2:0]});
            chk(adc_pb_sel, conv_rows[i][5:2]);
            chk(dac_pb_sel, conv_rows[i][1:0]);
        end
        wr(8'h40, 8'h86);
        chk(pb_active, 9'h000);
        // reset in mid run brings the registers and the level back
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        chk(pb_attenuation, 9'h100);
        rd(8'h3F, 8'h00);
        rd(8'h3E, 8'h11);
        end_sim;
    end
endmodule // tb_top
